/* rtl/rsp_device.sv */
// Purpose: Serial slave register port with a 256-byte memory window.
// Assumes: Mode 3 (clock idles high); pins synchronised to mclk.
// Notes:   Time, alarms and converter are outside; ports carry their hooks.
// Behaviour
// - Inhibit bit blocks conversions on backup supply
// - Memory pointer selects one of 256 bytes
// - Host loads memory pointer before window access
// - Memory pointer wraps from ffh to 00h
// - Window read and write use pointer location
// - Window burst keeps register pointer, bumps memory pointer
// - Four wires; chip select low frames transfer
// - Host clocks once per bit, eight-bit groups
// - Bytes travel most significant bit first
// - First byte addresses; top bit picks direction
// - Write samples input; output stays undriven
// - Read shifts output; input line ignored
// - Output undriven until full read byte ready
// - Register pointer advances each byte in burst, except at the memory data window
// - Pointer wraps 13h to 00h, 93h to 80h
// - Time copied at select fall and read wrap
// - Alarm matching uses internal time, not copy
// - Memory pointer and data need no reset
`timescale 1ns/1ps
module rsp_device (
  input  wire logic       mclk,
  input  wire logic       rst_b,
  rsp_if.dev              link,
  input  wire logic       on_backup,   // Running from backup supply
  input  wire logic       conv_due,    // Converter timer asks to convert
  output logic            conv_start,  // Start automatic conversion
  output logic            time_snap,   // Copy internal time to buffers
  output logic [6:0]      ext_addr,    // Pointer for other registers
  input  wire logic [7:0] ext_rdata,   // Data of other registers
  input  wire logic       ext_valid,   // Other register is implemented
  output logic            ext_we,      // Write strobe for other regs
  output logic [7:0]      ext_wdata    // Write data for other regs
);
  typedef enum {IDLE, ADDR, WR, RD} rsp_st_e;
  typedef struct packed {
    logic [2:0] cs_s;     // Select synchroniser and last value
    logic [2:0] ck_s;     // Clock synchroniser and last value
    logic [1:0] di_s;     // Data synchroniser
    rsp_st_e    st;       // Transfer phase
    logic [6:0] ptr;      // Register pointer
    logic [2:0] bitn;     // Bit count in byte
    logic [7:0] sh;       // Shift register
    logic       oe;       // Output enable
    logic       dout;     // Output bit
    logic [7:0] tctl;     // Conversion control
    logic       snap;     // Time copy pulse
    logic       we;       // External write pulse
    logic [7:0] wd;       // External write data
  } rsp_dev_s;
  rsp_dev_s r, next_r;
  logic [7:0] mem [256];  // Memory array, no reset
  logic [7:0] sram_ptr;   // Memory pointer, no reset
  logic       mem_we;     // Memory write strobe
  logic       ptr_we;     // Pointer load strobe
  logic       ptr_inc;    // Pointer increment strobe
  logic [7:0] rbyte;      // Byte chosen for reading
  logic       rvalid;     // Chosen location is implemented
  logic       fall, rise; // Clock edges seen on synced clock
  logic       cs_fall;    // Select just went low

  assign fall    = r.ck_s[2] & ~r.ck_s[1];
  assign rise    = ~r.ck_s[2] & r.ck_s[1];
  assign cs_fall = r.cs_s[2] & ~r.cs_s[1];

  // Read multiplexer over implemented locations
  always_comb begin
    rvalid = 1'b1;
    case (r.ptr)
      rsp_pkg::REG_TEMP_CTRL: rbyte = r.tctl;
      rsp_pkg::REG_SRAM_PTR:  rbyte = sram_ptr;
      rsp_pkg::REG_SRAM_DATA: rbyte = mem[sram_ptr];
      default: begin
        rbyte  = ext_rdata;
        rvalid = ext_valid;
      end
    endcase
  end

  // Pointer advance with the same wrap for both directions; window location holds
  function automatic logic [6:0] adv(input logic [6:0] p);
    if (p == rsp_pkg::REG_SRAM_DATA)
      adv = p;
    else if (p == rsp_pkg::REG_WRAP_TOP)
      adv = rsp_pkg::REG_WRAP_BASE;
    else
      adv = 7'(p + 7'h01);
  endfunction : adv

  // Next-state logic
  always_comb begin
    next_r      = r;
    next_r.cs_s = {r.cs_s[1:0], link.cs_b};
    next_r.ck_s = {r.ck_s[1:0], link.sclk};
    next_r.di_s = {r.di_s[0], link.mosi};
    next_r.snap = 1'b0;
    next_r.we   = 1'b0;
    mem_we      = 1'b0;
    ptr_we      = 1'b0;
    ptr_inc     = 1'b0;
    // Advance past an outside register once its write has been issued
    if (r.we)
      next_r.ptr = adv(r.ptr);
    if (r.cs_s[1]) begin
      next_r.st = IDLE;
      next_r.oe = 1'b0;
    end else if (cs_fall) begin
      next_r.st   = ADDR;
      next_r.bitn = 3'h0;
      next_r.snap = 1'b1;
    end else if (r.st == RD) begin
      // Shift on falling edge, input ignored
      if (fall) begin
        next_r.oe   = rvalid;
        next_r.dout = r.sh[7];
        next_r.sh   = {r.sh[6:0], 1'b0};
        next_r.bitn = 3'(r.bitn + 3'h1);
        if (r.bitn == 3'h7) begin
          next_r.ptr = adv(r.ptr);
          if (r.ptr == rsp_pkg::REG_WRAP_TOP)
            next_r.snap = 1'b1;
          if (r.ptr == rsp_pkg::REG_SRAM_DATA)
            ptr_inc = 1'b1;
        end
      end
      if (!fall && r.bitn == 3'h0)
        next_r.sh = rbyte;                         // Hold byte to send
    end else if (r.st != IDLE && rise) begin
      // Sample input on rising edge
      next_r.sh   = {r.sh[6:0], r.di_s[1]};
      next_r.bitn = 3'(r.bitn + 3'h1);
      if (r.bitn == 3'h7) begin
        if (r.st == ADDR) begin
          next_r.ptr = next_r.sh[6:0];
          if (next_r.sh[rsp_pkg::DIR_BIT]) begin
            next_r.st = WR;
          end else begin
            next_r.st = RD;
            next_r.sh = 8'h00;                     // Loaded before fall
          end
        end else begin
          case (r.ptr)
            rsp_pkg::REG_TEMP_CTRL:
              next_r.tctl = {7'h00, next_r.sh[rsp_pkg::INHIBIT_BIT]};
            rsp_pkg::REG_SRAM_PTR:  ptr_we = 1'b1;
            rsp_pkg::REG_SRAM_DATA: begin
              mem_we  = 1'b1;
              ptr_inc = 1'b1;
            end
            default: begin
              next_r.we = 1'b1;
              next_r.wd = next_r.sh;
            end
          endcase
          if (!next_r.we)
            next_r.ptr = adv(r.ptr);
        end
      end
    end
    // Enable rises only at a read fall, so address bytes stay undriven
  end

  // State register
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      r      <= '0;
      r.cs_s <= 3'h7;
      r.ck_s <= 3'h7;
      r.st   <= IDLE;
      r.tctl <= rsp_pkg::TEMP_CTRL_RESET;
    end else begin
      r <= next_r;
    end
  end

  // Memory and its pointer; written pointer first, else increments
  always_ff @(posedge mclk) begin
    if (mem_we)
      mem[sram_ptr] <= next_r.sh;
    if (ptr_we)
      sram_ptr <= next_r.sh;
    else if (ptr_inc)
      sram_ptr <= 8'(sram_ptr + 8'h01);
  end

  assign link.miso_o  = r.dout;
  assign link.miso_oe = r.oe & (r.st == RD);
  // Conversions held off on backup when inhibited
  assign conv_start = conv_due & ~(on_backup & r.tctl[rsp_pkg::INHIBIT_BIT]);
  assign time_snap  = r.snap;    // Alarm logic watches internal time
  assign ext_addr   = r.ptr;
  assign ext_we     = r.we;
  assign ext_wdata  = r.wd;
endmodule : rsp_device

/* pkg/rsp_pkg.sv */
// Purpose: Shared constants for the serial register port and its host.
// Assumes: Byte-wide registers, 7-bit register pointer, 256-byte memory.
// Notes:   Timing constants are in ns with mclk at 100 MHz; HALF_CYC gives mclk cycles.
package rsp_pkg;
  localparam logic [6:0] REG_TEMP_CTRL   = 7'h13; // Conversion control
  localparam logic [6:0] REG_SRAM_PTR    = 7'h18; // Memory pointer
  localparam logic [6:0] REG_SRAM_DATA   = 7'h19; // Memory data window
  localparam logic [6:0] REG_WRAP_TOP    = 7'h13; // Last register in wrap
  localparam logic [6:0] REG_WRAP_BASE   = 7'h00; // Wrap target
  localparam int         INHIBIT_BIT     = 0;     // Inhibit bit position
  localparam int         DIR_BIT         = 7;     // Address byte direction
  localparam logic [7:0] TEMP_CTRL_RESET = 8'h00; // Control reset value
  localparam logic [7:0] SRAM_PTR_LAST   = 8'hff; // Pointer before wrap
  // Host-side register map of its own command port
  localparam logic [1:0] HOST_CMD        = 2'h0;  // Write: bit 0 low opens frame, high ends
  localparam logic [1:0] HOST_TXD        = 2'h1;  // Write: next data byte
  localparam logic [1:0] HOST_STAT       = 2'h2;  // Read: status
  localparam logic [1:0] HOST_RXD        = 2'h3;  // Read: last byte in
  localparam int         HALF_NS         = 80;    // Shift clock half period
  localparam int         CLK_NS          = 10;    // mclk period
  localparam int         HALF_CYC        = HALF_NS / CLK_NS;
endpackage : rsp_pkg

/* pkg/rsp_if.sv */
// Purpose: Four-wire serial link between the host and the register port.
// Assumes: Output data line is three signals; bench resolves the wire.
// Notes:   miso_oe high while the device drives the line.
`timescale 1ns/1ps
interface rsp_if;
  logic cs_b;     // Chip select, active low
  logic sclk;     // Shift clock from host
  logic mosi;     // Serial data into device
  logic miso_o;   // Device output data
  logic miso_oe;  // Device output enable
  logic miso_i;   // Resolved line seen by host
  modport dev  (input cs_b, sclk, mosi, miso_i, output miso_o, miso_oe);
  modport host (output cs_b, sclk, mosi, input miso_i, miso_o, miso_oe);
endinterface : rsp_if

/* rtl/rsp_host.sv */
// Purpose: Host end that drives the four-wire link, mode 3.
// Assumes: Software writes a command, then data bytes; reads status.
// Notes:   Clock made by a divider; idles high between frames.
`timescale 1ns/1ps
module rsp_host (
  input  wire logic       mclk,
  input  wire logic       rst_b,
  rsp_if.host             link,
  input  wire logic [1:0] addr,    // Command port address
  input  wire logic [7:0] wdata,   // Command port write data
  input  wire logic       wr,      // Write strobe
  input  wire logic       rd,      // Read strobe
  output logic [7:0]      rdata    // Read data, one cycle later
);
  typedef enum {H_IDLE, H_SHIFT, H_WAIT} rsp_hst_e;
  typedef struct packed {
    rsp_hst_e   st;     // Phase
    logic       cs_b;   // Chip select
    logic       sclk;   // Shift clock
    logic [7:0] tx;     // Outgoing byte
    logic [7:0] rx;     // Incoming byte
    logic [2:0] bitn;   // Bit count
    logic [3:0] div;    // Half-period divider
    logic       busy;   // Byte in flight
    logic [1:0] mi_s;   // Input synchroniser
    logic [7:0] rd_q;   // Read data register
  } rsp_hst_s;
  rsp_hst_s r, next_r;

  // Next-state: bytes MSB first, one clock per bit, groups of eight
  always_comb begin
    next_r      = r;
    next_r.mi_s = {r.mi_s[0], link.miso_i};
    next_r.rd_q = 8'h00;
    if (rd) begin
      case (addr)
        rsp_pkg::HOST_STAT: next_r.rd_q = {7'h00, r.busy};
        rsp_pkg::HOST_RXD:  next_r.rd_q = r.rx;
        default:            next_r.rd_q = 8'h00;
      endcase
    end
    case (r.st)
      H_IDLE: begin
        if (wr && addr == rsp_pkg::HOST_CMD) begin
          next_r.cs_b = wdata[0];   // Bit 0 low opens frame, high ends
        end else if (wr && addr == rsp_pkg::HOST_TXD && !r.cs_b) begin
          next_r.tx   = wdata;
          next_r.busy = 1'b1;
          next_r.bitn = 3'h0;
          next_r.div  = 4'h0;
          next_r.st   = H_SHIFT;
        end
      end
      H_SHIFT: begin
        next_r.div = 4'(r.div + 4'h1);
        if (r.div == 4'(rsp_pkg::HALF_CYC - 1)) begin
          next_r.div  = 4'h0;
          next_r.sclk = ~r.sclk;
          if (r.sclk) begin
            // Falling: device shifts out; host presents its next bit
            // here so the bit is settled at the sampling rise
            if (r.bitn != 3'h0)
              next_r.tx = {r.tx[6:0], 1'b0};
          end else begin
            next_r.rx   = {r.rx[6:0], r.mi_s[1]};
            next_r.bitn = 3'(r.bitn + 3'h1);
            if (r.bitn == 3'h7)
              next_r.st = H_WAIT;
          end
        end
      end
      H_WAIT: begin
        next_r.busy = 1'b0;
        next_r.st   = H_IDLE;
      end
      default: next_r.st = H_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      r      <= '0;
      r.st   <= H_IDLE;
      r.cs_b <= 1'b1;
      r.sclk <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign link.cs_b = r.cs_b;
  assign link.sclk = r.sclk;
  assign link.mosi = r.tx[7];
  assign rdata     = r.rd_q;
endmodule : rsp_host

/* sim/rsp_checker.sv */
// Purpose: Wire checks on the link between host and register port.
// Assumes: Mode 3, shift clock half period of eight mclk cycles.
// Notes:   Bit count restarts at each select fall.
`timescale 1ns/1ps
module rsp_checker (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic cs_b,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic miso_o,
  input wire logic miso_oe,
  input wire logic miso_i
);
  logic [7:0] bits; // Shift clock rises seen in frame
  logic       wr;   // Frame is a write frame
  logic       cs_q; // Select one cycle ago
  logic       sc_q; // Shift clock one cycle ago
  // Counts rises and keeps the direction bit of the address byte
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      bits <= 8'h00;
      wr   <= 1'b1;
      cs_q <= 1'b1;
      sc_q <= 1'b1;
    end else begin
      cs_q <= cs_b;
      sc_q <= sclk;
      if (cs_q && !cs_b) begin
        bits <= 8'h00;
        wr   <= 1'b1;
      end else if (sclk && !sc_q) begin
        bits <= bits + 8'h01;
        if (bits == 8'h00) wr <= mosi;
      end
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  sclk_idle_a: assert property (cs_b |-> sclk)
    else $error("shift clock low while deselected");
  sclk_frame_a: assert property ($changed(sclk) |-> !cs_b)
    else $error("shift clock moved outside a frame");
  low_half_a: assert property ($fell(sclk) |-> !sclk [*8] ##1 sclk)
    else $error("shift clock low phase not eight cycles");
  mosi_hold_a: assert property (sclk && $past(sclk) && bits[2:0] != 3'h0
    |-> $stable(mosi))
    else $error("input line moved mid byte with clock high");
  oe_drop_a: assert property (cs_b [*5] |-> !miso_oe)
    else $error("output driven while deselected");
  oe_addr_a: assert property (miso_oe |-> bits >= 8'h08)
    else $error("output driven before address byte done");
  oe_write_a: assert property (miso_oe |-> !wr)
    else $error("output driven in a write frame");
  shift_edge_a: assert property (miso_oe && $past(miso_oe)
    && $changed(miso_o) |-> !sclk)
    else $error("output bit changed with clock high");
  rd_oe_c: cover property (!wr && miso_oe);
  frame_c: cover property ($fell(cs_b));
  burst_c: cover property (bits == 8'h18);
endmodule : rsp_checker

/* sim/rsp_tb.sv */
// Purpose: Drives host port; both link ends face each other.
// Assumes: Other registers modelled as address xor 5ah.
// Notes:   Undriven output line shows the inverse of its last bit.
`timescale 1ns/1ps
module rsp_tb;
  logic       mclk = 1'b0, rst_b = 1'b0;   // Clock and reset
  logic [1:0] addr = 2'h0;                 // Host port address
  logic [7:0] wdata = 8'h00, rdata;        // Host port data
  logic       wr = 1'b0, rd = 1'b0;        // Host port strobes
  logic       on_backup = 1'b0, conv_due = 1'b0; // Supply and timer
  logic       conv_start, time_snap, ext_we, ext_valid, last_o = 1'b0;
  logic [6:0] ext_addr, we_addr = 7'h7f;   // Pointer, last written
  logic [7:0] ext_rdata, ext_wdata, we_data = 8'h00, snaps = 8'h00;
  logic       oe_seen = 1'b0;              // Output driven in frame
  logic [7:0] txq[$], rxq[$];              // Frame bytes out and in
  int         mismatches = 0, num_checks = 0, cycles = 0;
  rsp_if link ();
  assign ext_rdata = {1'b0, ext_addr} ^ 8'h5a;
  assign ext_valid = ext_addr < 7'h14;
  assign link.miso_i = link.miso_oe ? link.miso_o : ~last_o;
  always #5 mclk = ~mclk;
  rsp_device i_rsp_device (.mclk, .rst_b, .link(link), .on_backup,
    .conv_due, .conv_start, .time_snap, .ext_addr, .ext_rdata,
    .ext_valid, .ext_we, .ext_wdata);
  rsp_host i_rsp_host (.mclk, .rst_b, .link(link), .addr, .wdata,
    .wr, .rd, .rdata);
  rsp_checker i_rsp_checker (.mclk, .rst_b, .cs_b(link.cs_b),
    .sclk(link.sclk), .mosi(link.mosi), .miso_o(link.miso_o),
    .miso_oe(link.miso_oe), .miso_i(link.miso_i));
  // Monitors of the device side and the run time limit
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (link.miso_oe === 1'b1) begin
      last_o <= link.miso_o;
      oe_seen <= 1'b1;
    end
    if (ext_we === 1'b1) begin
      we_addr <= ext_addr;
      we_data <= ext_wdata;
    end
    if (time_snap === 1'b1) snaps <= snaps + 8'h01;
    if (cycles == 60000) begin
      mismatches = mismatches + 1;
      test_done();
    end
  end
  task automatic check(input string what, input logic [7:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic bus_wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask : bus_wr
  task automatic bus_rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : bus_rd
  // One framed transfer of all bytes in txq
  task automatic frame();
    logic [7:0] s;
    int         n;
    rxq = {};
    bus_wr(rsp_pkg::HOST_CMD, 8'h00);
    foreach (txq[i]) begin
      bus_wr(rsp_pkg::HOST_TXD, txq[i]);
      n = 0;
      do begin
        bus_rd(rsp_pkg::HOST_STAT, s);
        n++;
      end while (s[0] !== 1'b0 && n < 400);
      check("byte done", s, 8'h00);
      bus_rd(rsp_pkg::HOST_RXD, s);
      rxq.push_back(s);
    end
    bus_wr(rsp_pkg::HOST_CMD, 8'h01);
    repeat (20) @(posedge mclk);
  endtask : frame
  task automatic t_wrap();
    txq = '{8'h93, 8'h01, 8'h3c};
    frame();
    check("wrap addr", {1'b0, we_addr}, 8'h00);
    check("wrap data", we_data, 8'h3c);
    snaps = 8'h00;
    txq = '{8'h13, 8'h00, 8'h00};
    frame();
    check("control", rxq[1], 8'h01);
    check("wrap read", rxq[2], 8'h5a);
    check("snapshots", snaps, 8'h02);
    $display("test wrap done");
  endtask : t_wrap
  task automatic t_conv();
    @(posedge mclk);
    on_backup <= 1'b1;
    conv_due <= 1'b1;
    @(posedge mclk);
    #1 check("inhibited", conv_start, 8'h00);
    @(posedge mclk);
    on_backup <= 1'b0;
    @(posedge mclk);
    #1 check("main supply", conv_start, 8'h01);
    $display("test conversion done");
  endtask : t_conv
  task automatic t_sram();
    txq = '{8'h98, 8'hff};
    frame();
    txq = '{8'h99, 8'ha1, 8'hb2};
    frame();
    txq = '{8'h18, 8'h00};
    frame();
    check("pointer", rxq[1], 8'h01);
    txq = '{8'h98, 8'hff};
    frame();
    txq = '{8'h19, 8'h00, 8'h00};
    frame();
    check("mem ff", rxq[1], 8'ha1);
    check("mem 00", rxq[2], 8'hb2);
    $display("test memory done");
  endtask : t_sram
  task automatic t_bad();
    oe_seen = 1'b0;
    txq = '{8'h1a, 8'h00};
    frame();
    check("unimpl drive", oe_seen, 8'h00);
    oe_seen = 1'b0;
    txq = '{8'h05, 8'h00};
    frame();
    check("valid drive", oe_seen, 8'h01);
    check("valid data", rxq[1], 8'h5f);
    $display("test unimplemented done");
  endtask : t_bad
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : test_done
  initial begin
    repeat (20) @(posedge mclk);
    rst_b <= 1'b1;
    t_wrap();
    t_conv();
    t_sram();
    t_bad();
    test_done();
  end
endmodule : rsp_tb
